//--- rtl/cpm_pkg.sv
// constants for the clock and power manager block
// assumes a byte-wide special-register port driven by the cpu core
package cpm_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CPM_SPEED_ADDR = 8'h8F;
    localparam logic [7:0] CPM_POWER_ADDR = 8'h87;
    localparam logic [7:0] CPM_SPEED_RST  = 8'h00;
    localparam logic [7:0] CPM_POWER_RST  = 8'h10;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CPM_DBL_BIT  = 0;
    localparam int CPM_IDLE_BIT = 0;
    localparam int CPM_PD_BIT   = 1;
    localparam int CPM_RSV_BIT  = 5;
    localparam int CPM_NUM_PER  = 7;
    // ----------------------------------------
    // cycle counts, in oscillator periods; CPM_WARM_MC in machine cycles
    // ----------------------------------------
    localparam int CPM_STD_PERIODS  = 12;
    localparam int CPM_DBL_PERIODS  = 6;
    localparam int CPM_WARM_MC      = 2;
    localparam int CPM_WARM_PERIODS = CPM_WARM_MC * CPM_STD_PERIODS;
    localparam logic [3:0] CPM_PH_LAST = 4'(CPM_STD_PERIODS - 1);
    localparam logic [3:0] CPM_PH_HALF = 4'(CPM_DBL_PERIODS - 1);
    localparam logic [4:0] CPM_WARM_LAST = 5'(CPM_WARM_PERIODS - 1);
    // ----------------------------------------
    // operating states, gray along run-idle-pdown-warm
    // ----------------------------------------
    typedef enum logic [1:0] {
        CPM_RUN   = 2'h0,
        CPM_IDLE  = 2'h1,
        CPM_PDOWN = 2'h3,
        CPM_WARM  = 2'h2
    } cpm_state_t;
endpackage

//--- rtl/cpm_clock_power_manager.sv
// clock speed selection and power reduction control
// assumes clk_i is the crystal input and cpu side signals are synchronous to it
//
// What this block does
// - speed bit clear gives 12 periods per cycle; set gives cpu 6 periods
// - peripheral speed bit clear selects 6 periods, set selects 12 periods
// - peripheral speed bits are ignored while double speed is off
// - speed select register reads zero after reset
// - internal reset requests act like a reset pin reset
// - idle stops cpu clock, peripherals keep running, state kept
// - idle request takes effect when the writing instruction completes
// - idle and powerdown together enter powerdown, no idle afterwards
// - enabled interrupt in idle clears idle request and restarts cpu
// - reset pin high clears idle request at once and restarts cpu
// - reset completion reinitialises state and fetches from address zero
// - between reset pin and internal reset, ram access is blocked
// - converter idle start lets conversion completion end idle
// - powerdown stops oscillator and every clock, state kept
// - powerdown request takes effect when the writing instruction completes
// - power control holds idle at bit 0, powerdown at bit 1
// - standard mode halves crystal before phase generator; double bypasses
// - double speed change lands only at a divided clock rising edge
module cpm_clock_power_manager
    import cpm_pkg::*;
(
    // clock and power-on reset
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    // reset sources
    input  wire logic                   rst_pin_i,
    input  wire logic                   int_rst_i,
    // special register port
    input  wire logic                   sfr_wr_i,
    input  wire logic                   sfr_rd_i,
    input  wire logic [7:0]             sfr_addr_i,
    input  wire logic [7:0]             sfr_wdata_i,
    output logic      [7:0]             sfr_rdata_o,
    // cpu and wake events
    input  wire logic                   instr_done_i,
    input  wire logic                   irq_i,
    input  wire logic                   adc_idle_start_i,
    input  wire logic                   adc_done_i,
    // clock enables and status
    output logic                        cpu_ce_o,
    output logic [cpm_pkg::CPM_NUM_PER-1:0] per_ce_o,
    output logic                        phase_en_o,
    output logic                        osc_run_o,
    output logic                        core_rst_o,
    output logic                        fetch_zero_o,
    output logic                        ram_block_o,
    output logic                        idle_o,
    output logic                        pdown_o
);
    import cpm_pkg::*;

    cpm_state_t state_r;
    logic [7:0] speed_r;
    logic [7:0] power_r;
    logic       x2_eff_r;
    logic       div2_r;
    logic [3:0] phase_r;
    logic [4:0] rst_cnt_r;
    logic       adc_wake_r;
    logic       fetch_r;
    logic       warm_req;
    logic       wake_pin;
    logic       osc_on;
    logic       tick_full;
    logic       tick_half;
    logic       wr_speed;
    logic       wr_power;

    assign wr_speed = sfr_wr_i && (sfr_addr_i == CPM_SPEED_ADDR);
    assign wr_power = sfr_wr_i && (sfr_addr_i == CPM_POWER_ADDR);

    // ----------------------------------------
    // reset handling
    // ----------------------------------------
    // the pin wakes clocks in the same cycle, before the warm reset lands
    assign wake_pin = rst_pin_i && (state_r != CPM_WARM);
    assign warm_req = int_rst_i || (rst_pin_i && rst_cnt_r == CPM_WARM_LAST);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_cnt_r <= 5'h00;
        end else if (!rst_pin_i) begin
            rst_cnt_r <= 5'h00;
        end else if (rst_cnt_r != CPM_WARM_LAST) begin
            rst_cnt_r <= rst_cnt_r + 5'h01;
        end
    end

    // ----------------------------------------
    // operating state
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= CPM_RUN;
        end else if (warm_req) begin
            state_r <= CPM_WARM;
        end else begin
            unique case (state_r)
                CPM_RUN: begin
                    if (instr_done_i && power_r[CPM_PD_BIT]) begin
                        state_r <= CPM_PDOWN;
                    end else if (instr_done_i && power_r[CPM_IDLE_BIT]) begin
                        state_r <= CPM_IDLE;
                    end
                end
                CPM_IDLE: begin
                    if (rst_pin_i || irq_i || (adc_wake_r && adc_done_i)) begin
                        state_r <= CPM_RUN;
                    end
                end
                CPM_PDOWN: begin
                    if (rst_pin_i) begin
                        state_r <= CPM_RUN;
                    end
                end
                CPM_WARM: begin
                    if (!rst_pin_i) begin
                        state_r <= CPM_RUN;
                    end
                end
            endcase
        end
    end

    // reset release points the core at code address zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fetch_r <= 1'b0;
        end else begin
            fetch_r <= (state_r == CPM_WARM) && !warm_req && !rst_pin_i;
        end
    end

    // converter idle start is latched at any time in run and held into idle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            adc_wake_r <= 1'b0;
        end else if (state_r != CPM_IDLE && state_r != CPM_RUN) begin
            adc_wake_r <= 1'b0;
        end else if (state_r == CPM_RUN && adc_idle_start_i) begin
            adc_wake_r <= 1'b1;
        end else if (state_r == CPM_IDLE && adc_done_i) begin
            adc_wake_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            speed_r <= CPM_SPEED_RST;
        end else if (state_r == CPM_WARM) begin
            speed_r <= CPM_SPEED_RST;
        end else if (wr_speed) begin
            speed_r <= sfr_wdata_i;
        end
    end

    // hardware clears win over a write: they are assigned after it in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            power_r <= CPM_POWER_RST;
        end else begin
            if (wr_power) begin
                power_r <= sfr_wdata_i;
                power_r[CPM_RSV_BIT] <= 1'b0;
            end
            if (rst_pin_i || warm_req || state_r == CPM_WARM) begin
                power_r[CPM_IDLE_BIT] <= 1'b0;
                power_r[CPM_PD_BIT] <= 1'b0;
            end else if (state_r == CPM_IDLE && (irq_i || (adc_wake_r && adc_done_i))) begin
                power_r[CPM_IDLE_BIT] <= 1'b0;
            end else if (state_r == CPM_RUN && instr_done_i && power_r[CPM_PD_BIT]) begin
                power_r[CPM_IDLE_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                CPM_SPEED_ADDR: sfr_rdata_o <= speed_r;
                CPM_POWER_ADDR: sfr_rdata_o <= power_r;
                default:        sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // clock generation
    // ----------------------------------------
    // the oscillator stops in powerdown; the reset pin restarts it at once
    assign osc_on = (state_r != CPM_PDOWN) || rst_pin_i;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div2_r <= 1'b0;
        end else if (osc_on) begin
            div2_r <= ~div2_r;
        end
    end

    // sampled only just before the divided clock rises, so no short cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            x2_eff_r <= 1'b0;
        end else if (osc_on && !div2_r) begin
            x2_eff_r <= speed_r[CPM_DBL_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_r <= 4'h0;
        end else if (osc_on) begin
            phase_r <= (phase_r == CPM_PH_LAST) ? 4'h0 : phase_r + 4'h1;
        end
    end

    assign tick_full = osc_on && (phase_r == CPM_PH_LAST);
    assign tick_half = osc_on && (phase_r == CPM_PH_HALF);
    assign phase_en_o = osc_on && (x2_eff_r || div2_r);

    // ----------------------------------------
    // clock enables
    // ----------------------------------------
    assign cpu_ce_o = (state_r == CPM_RUN || wake_pin)
                      && (tick_full || (x2_eff_r && tick_half));

    // a unit runs double only when double speed is on and its bit is clear
    genvar g;
    generate
        for (g = 0; g < CPM_NUM_PER; g++) begin : g_per
            assign per_ce_o[g] = tick_full
                || (tick_half && x2_eff_r && !speed_r[g+1]);
        end
    endgenerate

    assign osc_run_o    = osc_on;
    assign core_rst_o   = (state_r == CPM_WARM);
    assign fetch_zero_o = fetch_r;
    assign ram_block_o  = wake_pin;
    assign idle_o       = (state_r == CPM_IDLE);
    assign pdown_o      = (state_r == CPM_PDOWN);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // a switch to double speed inside the gap may bring the half tick in early
    std_cpu_gap_a: assert property (cpu_ce_o && !x2_eff_r |=> (!cpu_ce_o || x2_eff_r)[*8])
        else $error("standard cpu enable too close");
    dbl_cpu_gap_a: assert property (cpu_ce_o && x2_eff_r && state_r == CPM_RUN |-> ##6
        (cpu_ce_o || !x2_eff_r || state_r != CPM_RUN))
        else $error("double cpu enable not every 6");
    per_speed_a: assert property (tick_half && x2_eff_r |-> per_ce_o == ~speed_r[7:1])
        else $error("peripheral speed bit not honoured");
    per_ignore_a: assert property (!x2_eff_r && !tick_full |-> per_ce_o == '0)
        else $error("peripheral fast while double off");
    spd_reset_a: assert property (state_r == CPM_WARM |=> speed_r == CPM_SPEED_RST)
        else $error("speed select not cleared by reset");
    int_reset_a: assert property (int_rst_i |=> core_rst_o)
        else $error("internal reset ignored");
    idle_gate_a: assert property (state_r == CPM_IDLE && !rst_pin_i |-> !cpu_ce_o)
        else $error("cpu clocked in idle");
    idle_wake_a: assert property (state_r == CPM_IDLE && irq_i && !warm_req
        |=> state_r == CPM_RUN && !power_r[CPM_IDLE_BIT])
        else $error("interrupt did not end idle");
    pd_first_a: assert property (state_r == CPM_RUN && instr_done_i && power_r[1:0] == 2'h3 && !warm_req
        && !rst_pin_i |=> state_r == CPM_PDOWN && !power_r[CPM_IDLE_BIT])
        else $error("powerdown not preferred over idle");
    pd_clock_a: assert property (state_r == CPM_PDOWN && !rst_pin_i
        |-> !osc_run_o && !cpu_ce_o && per_ce_o == '0)
        else $error("clock running in powerdown");
    pin_wake_a: assert property (rst_pin_i && state_r == CPM_IDLE |=> !power_r[CPM_IDLE_BIT])
        else $error("reset pin did not clear idle");
    fetch_zero_a: assert property (state_r == CPM_WARM && !rst_pin_i && !int_rst_i
        |=> fetch_zero_o && state_r == CPM_RUN)
        else $error("no fetch from zero after reset");
    sync_switch_a: assert property ($changed(x2_eff_r) |-> $past(div2_r) == 1'b0)
        else $error("double speed changed off edge");
endmodule

//--- tb/cpm_core_model.sv
// stand-in for the cpu core and peripherals fed by the clock enables
// assumes enables are one-cycle pulses on clk_i
module cpm_core_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // enables from the manager
    input  wire logic        cpu_ce_i,
    input  wire logic [6:0]  per_ce_i,
    // bench control
    input  wire logic        clr_i,
    input  wire logic        req_i,
    // observed counts and instruction end
    output logic      [7:0]  cpu_cnt_o,
    output logic      [55:0] per_cnt_o,
    output logic             instr_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend_r;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_cnt_o <= 8'h00;
            per_cnt_o <= '0;
        end else if (clr_i) begin
            cpu_cnt_o <= 8'h00;
            per_cnt_o <= '0;
        end else begin
            cpu_cnt_o <= cpu_cnt_o + 8'(cpu_ce_i);
            for (int g = 0; g < 7; g++) begin
                per_cnt_o[g*8 +: 8] <= per_cnt_o[g*8 +: 8] + 8'(per_ce_i[g]);
            end
        end
    end
    // an instruction ends only on a machine cycle, so a halted cpu never ends one
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_r       <= 1'b0;
            instr_done_o <= 1'b0;
        end else begin
            instr_done_o <= pend_r & cpu_ce_i;
            pend_r       <= req_i | (pend_r & ~cpu_ce_i);
        end
    end
endmodule

//--- tb/cpm_clock_power_manager_tb_top.sv
// bench for the clock and power manager: register calls and enable counts
// assumes the core model above stands on the enable side
module cpm_clock_power_manager_tb_top import cpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, rst_pin = 0, int_rst = 0, wr = 0, rd = 0;
    logic done, irq = 0, adc_st = 0, adc_done = 0, clr = 0, req = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, cpu_cnt;
    logic [6:0] per_ce;
    logic [55:0] per_cnt;
    logic cpu_ce, phase_en, osc_run, core_rst, fetch_zero, ram_block, idle, pdown;
    int bad_count, checked, cycles, n;
    always #20 clk = ~clk;
    cpm_clock_power_manager u_dut (.clk_i(clk), .rstn_i(rstn), .rst_pin_i(rst_pin), .int_rst_i(int_rst),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .instr_done_i(done), .irq_i(irq), .adc_idle_start_i(adc_st), .adc_done_i(adc_done),
        .cpu_ce_o(cpu_ce), .per_ce_o(per_ce), .phase_en_o(phase_en), .osc_run_o(osc_run),
        .core_rst_o(core_rst), .fetch_zero_o(fetch_zero), .ram_block_o(ram_block), .idle_o(idle),
        .pdown_o(pdown));
    cpm_core_model u_core (.clk_i(clk), .rstn_i(rstn), .cpu_ce_i(cpu_ce), .per_ce_i(per_ce), .clr_i(clr),
        .req_i(req), .cpu_cnt_o(cpu_cnt), .per_cnt_o(per_cnt), .instr_done_o(done));
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
        @(negedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        chk(rdata, e);
        @(negedge clk);
    endtask
    // window of 120 periods holds whole machine cycles whatever the phase
    task automatic rate(input logic [7:0] ec, input logic [7:0] ep, input logic [6:0] slow);
        repeat (4) @(negedge clk);
        clr = 1;
        @(negedge clk);
        clr = 0;
        repeat (120) @(negedge clk);
        chk(cpu_cnt, ec);
        for (int g = 0; g < 7; g++) chk(per_cnt[g*8 +: 8], slow[g] ? 8'h0A : ep);
    endtask
    task automatic phase(input int e);
        n = 0;
        repeat (12) begin
            @(negedge clk);
            n += int'(phase_en === 1'b1);
        end
        chk(8'(n), 8'(e));
    endtask
    task automatic enter;
        req = 1;
        @(negedge clk);
        req = 0;
        for (int i = 0; i < 40 && idle !== 1'b1 && pdown !== 1'b1; i++) @(negedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            close_out;
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1;
        @(negedge clk);
        rd_reg(CPM_SPEED_ADDR, CPM_SPEED_RST);
        rd_reg(CPM_POWER_ADDR, CPM_POWER_RST);
        rd_reg(8'h80, 8'h00);
        rate(8'h0A, 8'h0A, 7'h00);
        phase(6);
        wr_reg(CPM_SPEED_ADDR, 8'hFE);
        rate(8'h0A, 8'h0A, 7'h00);
        wr_reg(CPM_SPEED_ADDR, 8'h01);
        rd_reg(CPM_SPEED_ADDR, 8'h01);
        rate(8'h14, 8'h14, 7'h00);
        phase(12);
        for (int g = 0; g < 7; g++) begin
            wr_reg(CPM_SPEED_ADDR, 8'h01 | (8'h02 << g));
            rate(8'h14, 8'h14, 7'h01 << g);
        end
        wr_reg(CPM_SPEED_ADDR, 8'h00);
        wr_reg(CPM_POWER_ADDR, 8'h1D);
        enter();
        chk(8'({idle, pdown}), 8'h02);
        rate(8'h00, 8'h0A, 7'h00);
        adc_done = 1;
        @(negedge clk);
        adc_done = 0;
        @(negedge clk);
        chk(8'(idle), 8'h01);
        irq = 1;
        for (int i = 0; i < 10 && idle !== 1'b0; i++) @(negedge clk);
        irq = 0;
        chk(8'(idle), 8'h00);
        rd_reg(CPM_POWER_ADDR, 8'h1C);
        adc_st = 1;
        @(negedge clk);
        adc_st = 0;
        wr_reg(CPM_POWER_ADDR, 8'h1D);
        enter();
        adc_done = 1;
        @(negedge clk);
        adc_done = 0;
        @(negedge clk);
        chk(8'({idle, pdown}), 8'h00);
        wr_reg(CPM_SPEED_ADDR, 8'h01);
        wr_reg(CPM_POWER_ADDR, 8'h1F);
        enter();
        chk(8'({pdown, idle, osc_run}), 8'h04);
        rate(8'h00, 8'h00, 7'h00);
        rst_pin = 1;
        #1;
        chk(8'({ram_block, osc_run}), 8'h03);
        repeat (24) @(negedge clk);
        chk(8'(core_rst), 8'h01);
        rst_pin = 0;
        for (int i = 0; i < 10 && fetch_zero !== 1'b1; i++) @(negedge clk);
        chk(8'({fetch_zero, pdown, idle}), 8'h04);
        rd_reg(CPM_SPEED_ADDR, 8'h00);
        rd_reg(CPM_POWER_ADDR, 8'h1C);
        rst_pin = 1;
        repeat (23) @(negedge clk);
        rst_pin = 0;
        repeat (3) @(negedge clk);
        chk(8'(core_rst), 8'h00);
        int_rst = 1;
        @(negedge clk);
        int_rst = 0;
        for (int i = 0; i < 4 && core_rst !== 1'b1; i++) @(negedge clk);
        chk(8'(core_rst), 8'h01);
        close_out;
    end
endmodule
